//--- ppfm_params.svh
// constants for the port pin function multiplexer
// assumes inclusion by the mux module, which reads every macro here
`ifndef PPFM_PARAMS_SVH
`define PPFM_PARAMS_SVH
// reset values of the control registers
`define PPFM_PORT2_SELECT_RST 8'h80
`define PPFM_PORT3_SELECT_RST 8'h00
`define PPFM_PORT4_SELECT_RST 8'h00
`define PPFM_DIR_RST 8'h00
`define PPFM_AE_RST 8'h00
// bit positions: crystal pin select and analog enables
`define PPFM_CRYSTAL_PIN_BIT 7
`define PPFM_AE0_PIN0_BIT 5
`define PPFM_AE0_PIN6_BIT 6
`define PPFM_AE0_PIN7_BIT 7
`define PPFM_AE1_PIN3_BIT 4
`define PPFM_AE1_PIN4_BIT 5
`define PPFM_AE1_PIN5_BIT 6
`endif

//--- ppfm_pkg.sv
// types for the port pin function multiplexer
// assumes nothing beyond the params header
package ppfm_pkg;
  typedef logic [7:0] ppfm_byte_t;
endpackage

//--- ppfm_mux.sv
// per-pin function mux for port 2 bit 7, port 3 and port 4 bits 0..5
// assumes control bits arrive from port registers in the same clock domain
`include "ppfm_params.svh"

// Functional notes
// - the crystal-output pin leaves reset with its select set and is plain i/o only once select is cleared.
// - port 3 bit 0 with select and analog enable group 0 bit 5 clear serves the a clock, and the b channel is forced to 3-wire spi.
// - port 3 bit 3 with select serves the b clock, and the a channel is forced to 3-wire spi.
// - with serial select on port 3 bits 0..5 the pad direction follows the serial module, except bit 0 while analog enable group 0 bit 5 is set.
// - port 3 bits 1..5 with select route b data-out/i2c data, b data-in/i2c clock, b clock, a transmit, a receive.
// - analog enable group 0 bits 5..7 disable driver and input of port 3 bits 0, 6, 7.
// - analog enable group 1 bits 4..6 disable driver and input of port 4 bits 3..5.
// - port 4 bits 0..2 with select feed capture a inputs when input and drive timer outputs when output.
// - port 4 bits 3..4 with select feed capture b inputs 0..1 or drive timer outputs 0..1.
// - port 4 bit 5 with select, output and analog enable group 1 bit 6 clear drives timer output 2 and routes no capture input.
// - port 3 bits 6..7 offer only general i/o or analog inputs.
// - after reset all covered pins except the crystal pin are general i/o with direction from the port.
module ppfm_mux (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PORT2_DIRECTION_BITS_WR,
  input wire logic [7:0] PORT2_DIRECTION_BITS_IN,
  input wire logic PORT2_FUNCTION_SELECT_BITS_WR,
  input wire logic [7:0] PORT2_FUNCTION_SELECT_BITS_IN,
  input wire logic PORT3_DIRECTION_BITS_WR,
  input wire logic [7:0] PORT3_DIRECTION_BITS_IN,
  input wire logic PORT3_FUNCTION_SELECT_BITS_WR,
  input wire logic [7:0] PORT3_FUNCTION_SELECT_BITS_IN,
  input wire logic PORT4_DIRECTION_BITS_WR,
  input wire logic [7:0] PORT4_DIRECTION_BITS_IN,
  input wire logic PORT4_FUNCTION_SELECT_BITS_WR,
  input wire logic [7:0] PORT4_FUNCTION_SELECT_BITS_IN,
  input wire logic ANALOG_ENABLE_GROUP0_WR,
  input wire logic [7:0] ANALOG_ENABLE_GROUP0_IN,
  input wire logic ANALOG_ENABLE_GROUP1_WR,
  input wire logic [7:0] ANALOG_ENABLE_GROUP1_IN,
  input wire logic [7:0] PORT2_OUT,
  input wire logic [7:0] PORT3_OUT,
  input wire logic [5:0] PORT4_OUT,
  input wire logic CRYSTAL_OUTPUT,
  input wire logic [5:0] SERIAL_PAD_OUT,
  input wire logic [5:0] SERIAL_PAD_OE,
  input wire logic [2:0] TIMER_B_OUTPUT,
  input wire logic PAD_P2_7_IN,
  input wire logic [7:0] PAD_P3_IN,
  input wire logic [5:0] PAD_P4_IN,
  output logic PAD_P2_7_OUT,
  output logic PAD_P2_7_OE,
  output logic [7:0] PAD_P3_OUT,
  output logic [7:0] PAD_P3_OE,
  output logic [5:0] PAD_P4_OUT,
  output logic [5:0] PAD_P4_OE,
  output logic PORT2_BIT7_IN,
  output logic [7:0] PORT3_IN,
  output logic [5:0] PORT4_IN,
  output logic [5:0] SERIAL_PAD_IN,
  output logic SERIAL_A_FORCE_3WIRE,
  output logic SERIAL_B_FORCE_3WIRE,
  output logic [2:0] TIMER_B_CAPTURE_INPUT_A,
  output logic [1:0] TIMER_B_CAPTURE_INPUT_B,
  output logic [7:0] PORT2_FUNCTION_SELECT_BITS,
  output logic [7:0] PORT3_FUNCTION_SELECT_BITS,
  output logic [7:0] PORT4_FUNCTION_SELECT_BITS,
  output logic [7:0] ANALOG_ENABLE_GROUP0,
  output logic [7:0] ANALOG_ENABLE_GROUP1
);

  // control register state
  ppfm_pkg::ppfm_byte_t p2_direction;
  ppfm_pkg::ppfm_byte_t p3_direction;
  ppfm_pkg::ppfm_byte_t p4_direction;
  ppfm_pkg::ppfm_byte_t p2_select;
  ppfm_pkg::ppfm_byte_t p3_select;
  ppfm_pkg::ppfm_byte_t p4_select;
  ppfm_pkg::ppfm_byte_t ae_group0;
  ppfm_pkg::ppfm_byte_t ae_group1;

  // next values of the control registers
  ppfm_pkg::ppfm_byte_t next_p2_direction;
  ppfm_pkg::ppfm_byte_t next_p3_direction;
  ppfm_pkg::ppfm_byte_t next_p4_direction;
  ppfm_pkg::ppfm_byte_t next_p2_select;
  ppfm_pkg::ppfm_byte_t next_p3_select;
  ppfm_pkg::ppfm_byte_t next_p4_select;
  ppfm_pkg::ppfm_byte_t next_ae_group0;
  ppfm_pkg::ppfm_byte_t next_ae_group1;

  // analog kill per pin
  logic [7:0] p3_ana;
  logic [5:0] p4_ana;

  // pad and routing next values
  logic next_p27_out;
  logic next_p27_oe;
  logic next_p2b7_in;
  logic next_fa3;
  logic next_fb3;
  logic [7:0] next_p3_out;
  logic [7:0] next_p3_oe;
  logic [7:0] next_p3_in;
  logic [5:0] next_p4_out;
  logic [5:0] next_p4_oe;
  logic [5:0] next_p4_in;
  logic [5:0] next_ser_in;
  logic [2:0] next_cap_a;
  logic [1:0] next_cap_b;

  // digital input behind the analog kill: low while the pin is analog, no floating buffer
  function automatic logic gated_input(logic pad, logic ana);
    return pad & ~ana;
  endfunction

  // write-load of control bits
  always_comb begin
    next_p2_direction = PORT2_DIRECTION_BITS_WR ? PORT2_DIRECTION_BITS_IN : p2_direction;
    next_p3_direction = PORT3_DIRECTION_BITS_WR ? PORT3_DIRECTION_BITS_IN : p3_direction;
    next_p4_direction = PORT4_DIRECTION_BITS_WR ? PORT4_DIRECTION_BITS_IN : p4_direction;
    next_p2_select = PORT2_FUNCTION_SELECT_BITS_WR ? PORT2_FUNCTION_SELECT_BITS_IN : p2_select;
    next_p3_select = PORT3_FUNCTION_SELECT_BITS_WR ? PORT3_FUNCTION_SELECT_BITS_IN : p3_select;
    next_p4_select = PORT4_FUNCTION_SELECT_BITS_WR ? PORT4_FUNCTION_SELECT_BITS_IN : p4_select;
    next_ae_group0 = ANALOG_ENABLE_GROUP0_WR ? ANALOG_ENABLE_GROUP0_IN : ae_group0;
    next_ae_group1 = ANALOG_ENABLE_GROUP1_WR ? ANALOG_ENABLE_GROUP1_IN : ae_group1;
  end

  // control registers with reset defaults
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      p2_select <= `PPFM_PORT2_SELECT_RST;
      p3_select <= `PPFM_PORT3_SELECT_RST;
      p4_select <= `PPFM_PORT4_SELECT_RST;
      p2_direction <= `PPFM_DIR_RST;
      p3_direction <= `PPFM_DIR_RST;
      p4_direction <= `PPFM_DIR_RST;
      ae_group0 <= `PPFM_AE_RST;
      ae_group1 <= `PPFM_AE_RST;
    end else begin
      p2_select <= next_p2_select;
      p3_select <= next_p3_select;
      p4_select <= next_p4_select;
      p2_direction <= next_p2_direction;
      p3_direction <= next_p3_direction;
      p4_direction <= next_p4_direction;
      ae_group0 <= next_ae_group0;
      ae_group1 <= next_ae_group1;
    end
  end

  // analog ownership of pins
  always_comb begin
    p3_ana = {ae_group0[`PPFM_AE0_PIN7_BIT], ae_group0[`PPFM_AE0_PIN6_BIT], 5'h00,
              ae_group0[`PPFM_AE0_PIN0_BIT]};
    p4_ana = {ae_group1[`PPFM_AE1_PIN5_BIT], ae_group1[`PPFM_AE1_PIN4_BIT],
              ae_group1[`PPFM_AE1_PIN3_BIT], 3'h0};
  end

  // pad drive and input routing
  always_comb begin
    // crystal pin: oscillator when selected, else port bit
    next_p27_out = p2_select[`PPFM_CRYSTAL_PIN_BIT] ? CRYSTAL_OUTPUT : PORT2_OUT[7];
    next_p27_oe = p2_select[`PPFM_CRYSTAL_PIN_BIT] | p2_direction[7];
    next_p2b7_in = PAD_P2_7_IN;
    // port 3: serial owns pins 0..5 when selected
    for (int i = 0; i < 8; i++) begin
      if (i < 6 && p3_select[i]) begin
        next_p3_out[i] = SERIAL_PAD_OUT[i];
        next_p3_oe[i] = SERIAL_PAD_OE[i];
      end else begin
        next_p3_out[i] = PORT3_OUT[i];
        next_p3_oe[i] = p3_direction[i];
      end
      if (p3_ana[i]) begin
        next_p3_oe[i] = 1'b0;
      end
      next_p3_in[i] = gated_input(PAD_P3_IN[i], p3_ana[i]);
    end
    for (int i = 0; i < 6; i++) begin
      next_ser_in[i] = gated_input(PAD_P3_IN[i], p3_ana[i]) & p3_select[i];
    end
    // shared pins force 3-wire mode on the losing channel
    next_fb3 = p3_select[0] & ~p3_ana[0];
    next_fa3 = p3_select[3];
    // port 4: timer b functions
    for (int i = 0; i < 6; i++) begin
      next_p4_out[i] = PORT4_OUT[i];
      if (p4_select[i]) begin
        next_p4_out[i] = TIMER_B_OUTPUT[i % 3];
      end
      next_p4_oe[i] = p4_direction[i] & ~p4_ana[i];
      next_p4_in[i] = gated_input(PAD_P4_IN[i], p4_ana[i]);
    end
    for (int i = 0; i < 3; i++) begin
      next_cap_a[i] = PAD_P4_IN[i] & p4_select[i] & ~p4_direction[i];
    end
    for (int i = 0; i < 2; i++) begin
      next_cap_b[i] = gated_input(PAD_P4_IN[i+3], p4_ana[i+3]) & p4_select[i+3] & ~p4_direction[i+3];
    end
  end

  // registered outputs
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PAD_P2_7_OUT <= 1'b0;
      PAD_P2_7_OE <= 1'b0;
      PAD_P3_OUT <= 8'h00;
      PAD_P3_OE <= 8'h00;
      PAD_P4_OUT <= 6'h00;
      PAD_P4_OE <= 6'h00;
      PORT2_BIT7_IN <= 1'b0;
      PORT3_IN <= 8'h00;
      PORT4_IN <= 6'h00;
      SERIAL_PAD_IN <= 6'h00;
      SERIAL_A_FORCE_3WIRE <= 1'b0;
      SERIAL_B_FORCE_3WIRE <= 1'b0;
      TIMER_B_CAPTURE_INPUT_A <= 3'h0;
      TIMER_B_CAPTURE_INPUT_B <= 2'h0;
      PORT2_FUNCTION_SELECT_BITS <= `PPFM_PORT2_SELECT_RST;
      PORT3_FUNCTION_SELECT_BITS <= `PPFM_PORT3_SELECT_RST;
      PORT4_FUNCTION_SELECT_BITS <= `PPFM_PORT4_SELECT_RST;
      ANALOG_ENABLE_GROUP0 <= `PPFM_AE_RST;
      ANALOG_ENABLE_GROUP1 <= `PPFM_AE_RST;
    end else begin
      PAD_P2_7_OUT <= next_p27_out;
      PAD_P2_7_OE <= next_p27_oe;
      PAD_P3_OUT <= next_p3_out;
      PAD_P3_OE <= next_p3_oe;
      PAD_P4_OUT <= next_p4_out;
      PAD_P4_OE <= next_p4_oe;
      PORT2_BIT7_IN <= next_p2b7_in;
      PORT3_IN <= next_p3_in;
      PORT4_IN <= next_p4_in;
      SERIAL_PAD_IN <= next_ser_in;
      SERIAL_A_FORCE_3WIRE <= next_fa3;
      SERIAL_B_FORCE_3WIRE <= next_fb3;
      TIMER_B_CAPTURE_INPUT_A <= next_cap_a;
      TIMER_B_CAPTURE_INPUT_B <= next_cap_b;
      PORT2_FUNCTION_SELECT_BITS <= p2_select;
      PORT3_FUNCTION_SELECT_BITS <= p3_select;
      PORT4_FUNCTION_SELECT_BITS <= p4_select;
      ANALOG_ENABLE_GROUP0 <= ae_group0;
      ANALOG_ENABLE_GROUP1 <= ae_group1;
    end
  end

  // checks: reset values and the crystal pin
  AST_CRYSTAL_SEL: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(RESET_N) |-> p2_select[`PPFM_CRYSTAL_PIN_BIT]) else $error("crystal select not set after reset");
  AST_CRYSTAL_DRIVE: assert property (@(posedge CLK) disable iff (!RESET_N)
    p2_select[7] |=> (PAD_P2_7_OE && PAD_P2_7_OUT == $past(CRYSTAL_OUTPUT)))
    else $error("crystal output not driven");
  AST_CRYSTAL_IO: assert property (@(posedge CLK) disable iff (!RESET_N)
    !p2_select[7] |=> (PAD_P2_7_OE == $past(p2_direction[7]) && PAD_P2_7_OUT == $past(PORT2_OUT[7])))
    else $error("crystal pin not plain i/o");
  AST_RESET_IO: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(RESET_N) |-> (p3_select == `PPFM_PORT3_SELECT_RST && p4_select == `PPFM_PORT4_SELECT_RST
      && ae_group0 == `PPFM_AE_RST && ae_group1 == `PPFM_AE_RST)) else $error("pins not general i/o after reset");

  // checks: serial functions and general i/o on port 3
  AST_B3WIRE: assert property (@(posedge CLK) disable iff (!RESET_N)
    (p3_select[0] && !ae_group0[5]) |=> SERIAL_B_FORCE_3WIRE) else $error("b channel not forced 3-wire");
  AST_B3WIRE_OFF: assert property (@(posedge CLK) disable iff (!RESET_N)
    !(p3_select[0] && !ae_group0[5]) |=> !SERIAL_B_FORCE_3WIRE) else $error("b channel forced without clock");
  AST_A3WIRE: assert property (@(posedge CLK) disable iff (!RESET_N)
    p3_select[3] |=> SERIAL_A_FORCE_3WIRE) else $error("a channel not forced 3-wire");
  AST_A3WIRE_OFF: assert property (@(posedge CLK) disable iff (!RESET_N)
    !p3_select[3] |=> !SERIAL_A_FORCE_3WIRE) else $error("a channel forced without clock");
  AST_SER_DIR: assert property (@(posedge CLK) disable iff (!RESET_N)
    p3_select[4] |=> PAD_P3_OE[4] == $past(SERIAL_PAD_OE[4])) else $error("serial direction ignored");
  AST_SER_OE0: assert property (@(posedge CLK) disable iff (!RESET_N)
    (p3_select[0] && !ae_group0[5]) |=> PAD_P3_OE[0] == $past(SERIAL_PAD_OE[0])) else $error("clock pin direction lost");
  AST_SER_TX: assert property (@(posedge CLK) disable iff (!RESET_N)
    p3_select[4] |=> PAD_P3_OUT[4] == $past(SERIAL_PAD_OUT[4])) else $error("transmit not routed");
  AST_SER_OUT1: assert property (@(posedge CLK) disable iff (!RESET_N)
    p3_select[1] |=> PAD_P3_OUT[1] == $past(SERIAL_PAD_OUT[1])) else $error("b data-out not routed");
  AST_SER_IN2: assert property (@(posedge CLK) disable iff (!RESET_N)
    p3_select[2] |=> SERIAL_PAD_IN[2] == $past(PAD_P3_IN[2])) else $error("b data-in not routed");
  AST_P3_HIGH_IO: assert property (@(posedge CLK) disable iff (!RESET_N)
    !ae_group0[6] |=> (PAD_P3_OE[6] == $past(p3_direction[6]) && PAD_P3_OUT[6] == $past(PORT3_OUT[6])))
    else $error("pin 6 not general i/o");

  // checks: analog kill
  AST_AE0_KILL: assert property (@(posedge CLK) disable iff (!RESET_N)
    ae_group0[6] |=> (!PAD_P3_OE[6] && !PORT3_IN[6])) else $error("analog pin still digital");
  AST_AE0_PIN0: assert property (@(posedge CLK) disable iff (!RESET_N)
    ae_group0[5] |=> (!PAD_P3_OE[0] && !PORT3_IN[0] && !SERIAL_PAD_IN[0])) else $error("analog pin 0 still digital");
  AST_AE0_PIN7: assert property (@(posedge CLK) disable iff (!RESET_N)
    ae_group0[7] |=> (!PAD_P3_OE[7] && !PORT3_IN[7])) else $error("analog pin 7 still digital");
  AST_AE1_KILL: assert property (@(posedge CLK) disable iff (!RESET_N)
    ae_group1[4] |=> (!PAD_P4_OE[3] && !TIMER_B_CAPTURE_INPUT_B[0])) else $error("analog pin still digital");
  AST_AE1_PIN5: assert property (@(posedge CLK) disable iff (!RESET_N)
    ae_group1[6] |=> (!PAD_P4_OE[5] && !PORT4_IN[5])) else $error("analog pin 5 still digital");
  AST_ANALOG_IN_LOW: assert property (@(posedge CLK) disable iff (!RESET_N)
    ae_group1[5] |=> (!PORT4_IN[4] && !TIMER_B_CAPTURE_INPUT_B[1])) else $error("analog pin input not low");

  // checks: timer b on port 4
  AST_CAPA: assert property (@(posedge CLK) disable iff (!RESET_N)
    (p4_select[1] && !p4_direction[1]) |=> TIMER_B_CAPTURE_INPUT_A[1] == $past(PAD_P4_IN[1])) else $error("capture a lost");
  AST_TB_OUT0: assert property (@(posedge CLK) disable iff (!RESET_N)
    (p4_select[0] && p4_direction[0]) |=> (PAD_P4_OE[0] && PAD_P4_OUT[0] == $past(TIMER_B_OUTPUT[0])))
    else $error("timer output 0 not driven on pin 0");
  AST_CAPB: assert property (@(posedge CLK) disable iff (!RESET_N)
    (p4_select[4] && !p4_direction[4] && !ae_group1[5]) |=> TIMER_B_CAPTURE_INPUT_B[1] == $past(PAD_P4_IN[4]))
    else $error("capture b lost");
  AST_TB_OUT3: assert property (@(posedge CLK) disable iff (!RESET_N)
    (p4_select[3] && p4_direction[3] && !ae_group1[4]) |=> (PAD_P4_OE[3] && PAD_P4_OUT[3] == $past(TIMER_B_OUTPUT[0])))
    else $error("timer output 0 not driven on pin 3");
  AST_TB2: assert property (@(posedge CLK) disable iff (!RESET_N)
    (p4_select[5] && p4_direction[5] && !ae_group1[6]) |=> (PAD_P4_OE[5] && PAD_P4_OUT[5] == $past(TIMER_B_OUTPUT[2])))
    else $error("timer output 2 not driven");
endmodule

//--- ppfm_peer.sv
// far-side model: peripheral drive levels and board pad levels
// assumes fixed levels suit the static routing checks of the bench
module ppfm_peer (
  output logic CRYSTAL_OUTPUT,
  output logic [5:0] SERIAL_PAD_OUT,
  output logic [5:0] SERIAL_PAD_OE,
  output logic [2:0] TIMER_B_OUTPUT,
  output logic PAD_P2_7_IN,
  output logic [7:0] PAD_P3_IN,
  output logic [5:0] PAD_P4_IN
);
  timeunit 1ns;
  timeprecision 1ps;
  // mixed patterns so a swapped or stuck route shows
  initial begin
    CRYSTAL_OUTPUT = 1'h1;
    SERIAL_PAD_OUT = 6'h2D;
    SERIAL_PAD_OE = 6'h1B;
    TIMER_B_OUTPUT = 3'h6;
    PAD_P2_7_IN = 1'h1;
    PAD_P3_IN = 8'hD9;
    PAD_P4_IN = 6'h1B;
  end
endmodule

//--- tb_top.sv
// testbench: writes port control registers and checks pin routing
// assumes ppfm_mux and the far-side model ppfm_peer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RESET_N;
  logic [7:0] wr, din, PORT2_OUT, PORT3_OUT;
  logic [5:0] PORT4_OUT;
  int fails, comparisons, cycles;
  // register write strobes and shared write data
  wire PORT2_DIRECTION_BITS_WR = wr[0], PORT2_FUNCTION_SELECT_BITS_WR = wr[1], PORT3_DIRECTION_BITS_WR = wr[2];
  wire PORT3_FUNCTION_SELECT_BITS_WR = wr[3], PORT4_DIRECTION_BITS_WR = wr[4], PORT4_FUNCTION_SELECT_BITS_WR = wr[5];
  wire ANALOG_ENABLE_GROUP0_WR = wr[6], ANALOG_ENABLE_GROUP1_WR = wr[7];
  wire [7:0] PORT2_DIRECTION_BITS_IN = din, PORT2_FUNCTION_SELECT_BITS_IN = din, PORT3_DIRECTION_BITS_IN = din;
  wire [7:0] PORT3_FUNCTION_SELECT_BITS_IN = din, PORT4_DIRECTION_BITS_IN = din, PORT4_FUNCTION_SELECT_BITS_IN = din;
  wire [7:0] ANALOG_ENABLE_GROUP0_IN = din, ANALOG_ENABLE_GROUP1_IN = din;
  wire CRYSTAL_OUTPUT, PAD_P2_7_IN, PAD_P2_7_OUT, PAD_P2_7_OE, PORT2_BIT7_IN;
  wire SERIAL_A_FORCE_3WIRE, SERIAL_B_FORCE_3WIRE;
  wire [5:0] SERIAL_PAD_OUT, SERIAL_PAD_OE, PAD_P4_IN, PAD_P4_OUT, PAD_P4_OE, PORT4_IN, SERIAL_PAD_IN;
  wire [2:0] TIMER_B_OUTPUT, TIMER_B_CAPTURE_INPUT_A;
  wire [1:0] TIMER_B_CAPTURE_INPUT_B;
  wire [7:0] PAD_P3_IN, PAD_P3_OUT, PAD_P3_OE, PORT3_IN, PORT2_FUNCTION_SELECT_BITS, PORT3_FUNCTION_SELECT_BITS;
  wire [7:0] PORT4_FUNCTION_SELECT_BITS, ANALOG_ENABLE_GROUP0, ANALOG_ENABLE_GROUP1;

  ppfm_mux u_dut (.*);
  ppfm_peer u_peer (.*);

  // 25 MHz clock
  initial begin
    CLK = 1'h0;
    forever #20 CLK = ~CLK;
  end

  // hang guard
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one-cycle write strobe, data held with it
  task automatic wr_reg(int idx, logic [7:0] v);
    @(posedge CLK);
    #1;
    din = v;
    wr = 8'h01 << idx;
    @(posedge CLK);
    #1;
    wr = 8'h00;
  endtask

  // register plus output stage have landed
  task automatic settle();
    repeat (3) @(posedge CLK);
    #1;
  endtask

  // main sequence
  initial begin
    RESET_N = 1'h0;
    wr = 8'h00;
    din = 8'h00;
    PORT2_OUT = 8'h00;
    PORT3_OUT = 8'hC3;
    PORT4_OUT = 6'h2A;
    repeat (8) @(posedge CLK);
    #1 RESET_N = 1'h1;
    settle();
    chk("port2_select", PORT2_FUNCTION_SELECT_BITS, 8'h80);
    chk("xtal_oe", PAD_P2_7_OE, 8'h01);
    chk("xtal_out", PAD_P2_7_OUT, 8'h01);
    chk("p3oe", PAD_P3_OE, 8'h00);
    chk("p4oe", PAD_P4_OE, 8'h00);
    chk("p3in", PORT3_IN, 8'hD9);
    // crystal pin as plain output, then input
    wr_reg(1, 8'h00);
    wr_reg(0, 8'h80);
    settle();
    chk("p27_oe", PAD_P2_7_OE, 8'h01);
    chk("p27_out", PAD_P2_7_OUT, 8'h00);
    wr_reg(0, 8'h00);
    settle();
    chk("p27_oe", PAD_P2_7_OE, 8'h00);
    chk("p27_in", PORT2_BIT7_IN, 8'h01);
    // port 3 general outputs, then serial functions
    wr_reg(2, 8'hFF);
    settle();
    chk("p3oe", PAD_P3_OE, 8'hFF);
    chk("p3out", PAD_P3_OUT, 8'hC3);
    wr_reg(3, 8'hFF);
    settle();
    chk("p3oe", PAD_P3_OE, 8'hDB);
    chk("p3out", PAD_P3_OUT, 8'hED);
    chk("ser_in", SERIAL_PAD_IN, 8'h19);
    chk("force_a", SERIAL_A_FORCE_3WIRE, 8'h01);
    chk("force_b", SERIAL_B_FORCE_3WIRE, 8'h01);
    // analog on port 3 pins 0, 6, 7
    wr_reg(6, 8'hE0);
    settle();
    chk("p3oe", PAD_P3_OE, 8'h1A);
    chk("p3in", PORT3_IN, 8'h18);
    chk("ser_in", SERIAL_PAD_IN, 8'h18);
    chk("force_a", SERIAL_A_FORCE_3WIRE, 8'h01);
    chk("force_b", SERIAL_B_FORCE_3WIRE, 8'h00);
    chk("ae0", ANALOG_ENABLE_GROUP0, 8'hE0);
    // port 4 capture inputs, then timer outputs
    wr_reg(5, 8'h3F);
    settle();
    chk("cap_a", TIMER_B_CAPTURE_INPUT_A, 8'h03);
    chk("cap_b", TIMER_B_CAPTURE_INPUT_B, 8'h03);
    chk("p4oe", PAD_P4_OE, 8'h00);
    chk("port4_select", PORT4_FUNCTION_SELECT_BITS, 8'h3F);
    wr_reg(4, 8'h3F);
    settle();
    chk("p4out", PAD_P4_OUT, 8'h36);
    chk("p4oe", PAD_P4_OE, 8'h3F);
    chk("cap_a", TIMER_B_CAPTURE_INPUT_A, 8'h00);
    // analog on port 4 pins 3..5
    wr_reg(7, 8'h70);
    settle();
    chk("p4oe", PAD_P4_OE, 8'h07);
    chk("p4in", PORT4_IN, 8'h03);
    chk("ae1", ANALOG_ENABLE_GROUP1, 8'h70);
    wr_reg(4, 8'h00);
    settle();
    chk("cap_b", TIMER_B_CAPTURE_INPUT_B, 8'h00);
    // second reset mid-run
    RESET_N = 1'h0;
    @(posedge CLK);
    #1 RESET_N = 1'h1;
    settle();
    chk("port2_select", PORT2_FUNCTION_SELECT_BITS, 8'h80);
    chk("port3_select", PORT3_FUNCTION_SELECT_BITS, 8'h00);
    chk("ae1", ANALOG_ENABLE_GROUP1, 8'h00);
    complete_run();
  end
endmodule
